// [src/lpms_top.sv]
// low power mode sequencer: modes, regulator, clock gating, wakeup and clock fallback
`timescale 1ns/1ps
`include "lpms_cfg.svh"
module lpms_top #(
    parameter int N_LINES = 16,
    parameter int N_INT_EV = 9,
    parameter int N_WAKEUP_PINS = 2,
    parameter int N_OSC_REQ = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus, write side
    input wire lpms_pkg::lpms_addr_t s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire lpms_pkg::lpms_word_t s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // register bus, read side
    input wire lpms_pkg::lpms_addr_t s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output lpms_pkg::lpms_word_t s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // processor side
    input wire logic core_sleep_req,
    input wire logic core_wake_event,
    // wakeup sources, oscillator requests and external clock, asynchronous
    input wire logic [N_LINES-1:0] external_event_lines,
    input wire logic [N_INT_EV-1:0] internal_event_lines,
    input wire logic [N_WAKEUP_PINS-1:0] wakeup_pins,
    input wire logic external_reset_pin_n,
    input wire logic independent_watchdog_reset,
    input wire logic rtc_event,
    input wire logic [N_OSC_REQ-1:0] periph_osc_req,
    input wire logic external_clock,
    // power and clock controls
    output logic regulator_on,
    output logic main_regulator_mode,
    output logic regulator_hiz,
    output logic core_power_on,
    output logic core_domain_rst,
    output logic cpu_clk_en,
    output logic core_clk_en,
    output logic pll_en,
    output logic internal_rc_oscillator_en,
    output logic external_crystal_oscillator_en,
    output logic [N_OSC_REQ-1:0] periph_osc_grant,
    output logic always_on_clk_en,
    output logic sysclk_external,
    // interrupt
    output logic irq
);
    import lpms_pkg::*;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    localparam int NA = N_LINES + N_INT_EV + N_WAKEUP_PINS + N_OSC_REQ + 4;
    logic [NA-1:0] async_in; // packed raw inputs
    logic [NA-1:0] sy1_reg; // first stage, read by sy2 only
    logic [NA-1:0] sy2_reg;
    logic [NA-1:0] sy3_reg;
    logic [NA-1:0] filt_reg; // value once stages two and three agree
    assign async_in = {external_clock, rtc_event, independent_watchdog_reset, ~external_reset_pin_n,
        periph_osc_req, wakeup_pins, internal_event_lines, external_event_lines};

    // three stages; a bit changes only when the last two agree
    always_ff @(posedge clk) begin
        if (rst) begin
            sy1_reg <= '0;
            sy2_reg <= '0;
            sy3_reg <= '0;
            filt_reg <= '0;
        end else begin
            sy1_reg <= async_in;
            sy2_reg <= sy1_reg;
            sy3_reg <= sy2_reg;
            filt_reg <= (sy2_reg & sy3_reg) | (filt_reg & (sy2_reg | sy3_reg));
        end
    end

    // field views of the filtered vector
    localparam int B_WK = N_LINES + N_INT_EV;
    localparam int B_OR = B_WK + N_WAKEUP_PINS;
    localparam int B_MS = B_OR + N_OSC_REQ;
    logic line_any; // any event line, pin or on-chip
    logic [N_WAKEUP_PINS-1:0] wk_prev_reg; // for rising edge detection
    logic wk_rise;
    logic [N_OSC_REQ-1:0] osc_req;
    logic stby_exit;
    logic xclk_prev_reg;
    logic xclk_edge;
    assign line_any = |filt_reg[B_WK-1:0];
    assign wk_rise = |(filt_reg[B_OR-1:B_WK] & ~wk_prev_reg);
    assign stby_exit = wk_rise | (|filt_reg[B_MS+2:B_MS]);
    assign xclk_edge = filt_reg[B_MS+3] ^ xclk_prev_reg;

    // previous values for edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            wk_prev_reg <= '0;
            xclk_prev_reg <= 1'b0;
        end else begin
            wk_prev_reg <= filt_reg[B_OR-1:B_WK];
            xclk_prev_reg <= filt_reg[B_MS+3];
        end
    end

    // ----------------------------------------
    // software registers
    // ----------------------------------------
    logic [`LPMS_CTRL_W-1:0] ctrl_reg; // mode choice and clock choice
    logic [`LPMS_IRQ_W-1:0] irq_stat_reg; // sticky events
    logic [`LPMS_IRQ_W-1:0] irq_mask_reg; // 1 lets the event interrupt
    logic [N_OSC_REQ-1:0] osc_en_reg; // peripherals allowed to wake the oscillator
    logic [`LPMS_IRQ_W-1:0] irq_set; // events from the sequencer
    logic aw_have_reg, w_have_reg;
    lpms_addr_t aw_addr_reg;
    lpms_word_t w_data_reg;
    logic w_lane0_reg; // byte lane 0 strobe; all fields sit in it
    logic wr_fire;
    logic wr_ctrl, wr_irq, wr_mask, wr_osc;
    assign osc_req = filt_reg[B_MS-1:B_OR] & osc_en_reg;

    // write address and data are taken independently
    assign s_axi_awready = !aw_have_reg;
    assign s_axi_wready = !w_have_reg;
    assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
    assign wr_ctrl = wr_fire && w_lane0_reg && aw_addr_reg == `LPMS_OFF_CTRL;
    assign wr_irq = wr_fire && w_lane0_reg && aw_addr_reg == `LPMS_OFF_IRQ;
    assign wr_mask = wr_fire && w_lane0_reg && aw_addr_reg == `LPMS_OFF_MASK;
    assign wr_osc = wr_fire && w_lane0_reg && aw_addr_reg == `LPMS_OFF_OSCEN;

    // write channel holding and response
    always_ff @(posedge clk) begin
        if (rst) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_lane0_reg <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LPMS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_lane0_reg <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // status is read only, so a write to it is refused too
                s_axi_bresp <= (aw_addr_reg == `LPMS_OFF_CTRL || aw_addr_reg == `LPMS_OFF_IRQ ||
                    aw_addr_reg == `LPMS_OFF_MASK || aw_addr_reg == `LPMS_OFF_OSCEN) ?
                    `LPMS_RESP_OKAY : `LPMS_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // control storage
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_reg <= `LPMS_CTRL_RST;
            irq_mask_reg <= `LPMS_MASK_RST;
            osc_en_reg <= `LPMS_OSCEN_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= w_data_reg[`LPMS_CTRL_W-1:0];
            end else if (irq_set[`LPMS_IRQ_CLK_FAIL]) begin
                ctrl_reg[`LPMS_CTRL_XTAL] <= 1'b0; // drop the failed choice
            end
            if (wr_mask) begin
                irq_mask_reg <= w_data_reg[`LPMS_IRQ_W-1:0];
            end
            if (wr_osc) begin
                osc_en_reg <= w_data_reg[N_OSC_REQ-1:0];
            end
        end
    end

    // sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat_reg <= '0;
        end else if (wr_irq) begin
            irq_stat_reg <= (irq_stat_reg & ~w_data_reg[`LPMS_IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
        end
    end
    assign irq = |(irq_stat_reg & irq_mask_reg);

    // ----------------------------------------
    // mode sequencer
    // ----------------------------------------
    lpms_state_e state_reg, state_next;
    logic [11:0] ramp_cnt_reg; // regulator settling time

    // next mode; a wake line beats an oscillator request
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ps_run: begin
                if (core_sleep_req && !ctrl_reg[`LPMS_CTRL_DEEP]) begin
                    state_next = ps_sleep;
                end else if (core_sleep_req && ctrl_reg[`LPMS_CTRL_STBY]) begin
                    state_next = ps_standby;
                end else if (core_sleep_req) begin
                    state_next = ps_stop;
                end
            end
            ps_sleep: begin
                if (core_wake_event) begin
                    state_next = ps_run;
                end
            end
            ps_stop: begin
                if (line_any) begin
                    state_next = ps_run;
                end else if (|osc_req && ctrl_reg[`LPMS_CTRL_LPREG]) begin
                    state_next = ps_stop_regup;
                end else if (|osc_req) begin
                    state_next = ps_stop_osc;
                end
            end
            ps_stop_regup: begin
                if (line_any) begin
                    state_next = ps_run;
                end else if (!(|osc_req)) begin
                    state_next = ps_stop;
                end else if (ramp_cnt_reg == 12'(`LPMS_REG_RAMP_CYC - 1)) begin
                    state_next = ps_stop_osc;
                end
            end
            ps_stop_osc: begin
                if (line_any) begin
                    state_next = ps_run;
                end else if (!(|osc_req)) begin
                    state_next = ps_stop;
                end
            end
            ps_standby: begin
                if (stby_exit) begin
                    state_next = ps_run;
                end
            end
            default: state_next = ps_run;
        endcase
    end

    // mode register and ramp counter
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= ps_run;
            ramp_cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            ramp_cnt_reg <= (state_reg == ps_stop_regup) ? ramp_cnt_reg + 12'h001 : 12'h000;
        end
    end

    // wake events into the status register
    assign irq_set[`LPMS_IRQ_WAKE_STOP] = (state_reg == ps_stop || state_reg == ps_stop_regup ||
        state_reg == ps_stop_osc) && state_next == ps_run;
    assign irq_set[`LPMS_IRQ_WAKE_STBY] = state_reg == ps_standby && state_next == ps_run;

    // power and clock controls, registered from the next mode
    always_ff @(posedge clk) begin
        if (rst) begin
            regulator_on <= 1'b1;
            main_regulator_mode <= 1'b1;
            regulator_hiz <= 1'b0;
            core_power_on <= 1'b1;
            core_domain_rst <= 1'b0;
            cpu_clk_en <= 1'b1;
            core_clk_en <= 1'b1;
            pll_en <= 1'b1;
            internal_rc_oscillator_en <= 1'b1;
            external_crystal_oscillator_en <= 1'b0;
            periph_osc_grant <= '0;
            always_on_clk_en <= 1'b1;
        end else begin
            regulator_on <= state_next != ps_standby;
            regulator_hiz <= state_next == ps_standby;
            core_power_on <= state_next != ps_standby;
            // domain logic is lost, so it leaves standby through reset
            core_domain_rst <= state_next == ps_standby;
            main_regulator_mode <= !(state_next == ps_standby ||
                (state_next == ps_stop && ctrl_reg[`LPMS_CTRL_LPREG]));
            cpu_clk_en <= state_next == ps_run;
            core_clk_en <= state_next == ps_run || state_next == ps_sleep;
            pll_en <= state_next == ps_run || state_next == ps_sleep;
            internal_rc_oscillator_en <= state_next == ps_run || state_next == ps_sleep ||
                state_next == ps_stop_osc;
            external_crystal_oscillator_en <= (state_next == ps_run || state_next == ps_sleep) &&
                ctrl_reg[`LPMS_CTRL_XTAL] && !irq_set[`LPMS_IRQ_CLK_FAIL];
            periph_osc_grant <= (state_next == ps_stop_osc) ? osc_req : '0;
            always_on_clk_en <= 1'b1;
        end
    end

    // ----------------------------------------
    // system clock choice and failure monitor
    // ----------------------------------------
    logic [11:0] fail_cnt_reg; // cycles since last external clock edge
    logic xtal_seen_reg; // an edge seen since the oscillator was enabled
    logic monitor_on;
    logic fail_hit;
    // stop and standby switch the oscillator off; that is not a failure
    assign monitor_on = external_crystal_oscillator_en && xtal_seen_reg;
    assign fail_hit = monitor_on && fail_cnt_reg == 12'(`LPMS_CLK_FAIL_CYC - 1);
    assign irq_set[`LPMS_IRQ_CLK_FAIL] = fail_hit;

    // watchdog counter over the external clock edges
    always_ff @(posedge clk) begin
        if (rst) begin
            fail_cnt_reg <= '0;
            xtal_seen_reg <= 1'b0;
        end else begin
            xtal_seen_reg <= external_crystal_oscillator_en && (xtal_seen_reg || xclk_edge);
            if (!monitor_on || xclk_edge || fail_hit) begin
                fail_cnt_reg <= '0;
            end else begin
                fail_cnt_reg <= fail_cnt_reg + 12'h001;
            end
        end
    end

    // clock select: rc after reset, external only once it runs
    always_ff @(posedge clk) begin
        if (rst) begin
            sysclk_external <= 1'b0;
        end else begin
            sysclk_external <= monitor_on && !fail_hit;
        end
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    // one read at a time, answered at the same edge that takes it
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `LPMS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `LPMS_RESP_OKAY;
            s_axi_rdata <= '0;
            case (s_axi_araddr)
                `LPMS_OFF_CTRL: s_axi_rdata[`LPMS_CTRL_W-1:0] <= ctrl_reg;
                `LPMS_OFF_STAT: begin
                    s_axi_rdata[5:0] <= state_reg;
                    s_axi_rdata[`LPMS_STAT_REG_MAIN] <= main_regulator_mode;
                    s_axi_rdata[`LPMS_STAT_XTAL_SEL] <= sysclk_external;
                    s_axi_rdata[`LPMS_STAT_XTAL_SEEN] <= xtal_seen_reg;
                end
                `LPMS_OFF_IRQ: s_axi_rdata[`LPMS_IRQ_W-1:0] <= irq_stat_reg;
                `LPMS_OFF_MASK: s_axi_rdata[`LPMS_IRQ_W-1:0] <= irq_mask_reg;
                `LPMS_OFF_OSCEN: s_axi_rdata[N_OSC_REQ-1:0] <= osc_en_reg;
                default: s_axi_rresp <= `LPMS_RESP_SLVERR; // unmapped
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_osc_req_lowreg;
        state_reg == ps_stop && ctrl_reg[`LPMS_CTRL_LPREG] && (|osc_req) && !line_any;
    endsequence
    sequence s_ramp_then_clock;
        state_reg == ps_stop_regup && main_regulator_mode;
    endsequence

    chk_run_regulator: assert property (state_reg == ps_run |-> regulator_on && main_regulator_mode)
        else $error("regulator not on in main mode during run");
    chk_standby_power: assert property (state_reg == ps_standby |-> !regulator_on && regulator_hiz
        && !core_power_on && !internal_rc_oscillator_en && !pll_en)
        else $error("standby left power or oscillators on");
    chk_sleep_halt: assert property (state_reg == ps_sleep |-> !cpu_clk_en && core_clk_en)
        else $error("sleep gating wrong");
    chk_stop_clocks: assert property (state_reg == ps_stop |-> !core_clk_en && !pll_en
        && !internal_rc_oscillator_en && !external_crystal_oscillator_en)
        else $error("clock running in stop");
    chk_stop_regsel: assert property (state_reg == ps_stop |->
        main_regulator_mode == !ctrl_reg[`LPMS_CTRL_LPREG])
        else $error("stop regulator mode ignores selection");
    chk_stop_wake: assert property (state_reg == ps_stop && line_any |=> state_reg == ps_run
        ##0 irq_stat_reg[`LPMS_IRQ_WAKE_STOP])
        else $error("event line did not leave stop");
    chk_regup_first: assert property (s_osc_req_lowreg |=> s_ramp_then_clock ##0 periph_osc_grant == '0)
        else $error("clock before regulator returned to main");
    chk_grant_main: assert property ($rose(|periph_osc_grant) |-> main_regulator_mode
        && $past(state_reg) == ps_stop_regup | $past(state_reg) == ps_stop)
        else $error("oscillator granted with regulator low");
    chk_standby_hold: assert property (state_reg == ps_standby && !stby_exit |=> state_reg == ps_standby)
        else $error("standby left without a valid source");
    chk_always_on: assert property (always_on_clk_en)
        else $error("always on clock stopped");
    chk_reset_clock: assert property (!xtal_seen_reg |=> !sysclk_external)
        else $error("external clock chosen before it ran");
    chk_fail_fallback: assert property (fail_hit |=> !sysclk_external && irq_stat_reg[`LPMS_IRQ_CLK_FAIL]
        && !ctrl_reg[`LPMS_CTRL_XTAL])
        else $error("clock failure did not fall back");
endmodule

// [src/lpms_cfg.svh]
// configuration constants for the low power mode sequencer
`ifndef LPMS_CFG_SVH
`define LPMS_CFG_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define LPMS_OFF_CTRL 8'h00
`define LPMS_OFF_STAT 8'h04
`define LPMS_OFF_IRQ 8'h08
`define LPMS_OFF_MASK 8'h0c
`define LPMS_OFF_OSCEN 8'h10
// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define LPMS_CTRL_DEEP 0
`define LPMS_CTRL_STBY 1
`define LPMS_CTRL_LPREG 2
`define LPMS_CTRL_XTAL 3
`define LPMS_CTRL_W 4
`define LPMS_CTRL_RST 4'h0
// ----------------------------------------
// status fields
// ----------------------------------------
`define LPMS_STAT_REG_MAIN 8
`define LPMS_STAT_XTAL_SEL 9
`define LPMS_STAT_XTAL_SEEN 10
// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define LPMS_IRQ_WAKE_STOP 0
`define LPMS_IRQ_WAKE_STBY 1
`define LPMS_IRQ_CLK_FAIL 2
`define LPMS_IRQ_W 3
`define LPMS_MASK_RST 3'h0
`define LPMS_OSCEN_RST 4'h0
// ----------------------------------------
// bus answers
// ----------------------------------------
`define LPMS_RESP_OKAY 2'h0
`define LPMS_RESP_SLVERR 2'h2
// ----------------------------------------
// timing
// ----------------------------------------
`define LPMS_CLK_PERIOD_NS 10
`define LPMS_REG_RAMP_NS 2000
`define LPMS_REG_RAMP_CYC ((`LPMS_REG_RAMP_NS + `LPMS_CLK_PERIOD_NS - 1) / `LPMS_CLK_PERIOD_NS)
`define LPMS_CLK_FAIL_NS 1000
`define LPMS_CLK_FAIL_CYC (`LPMS_CLK_FAIL_NS / `LPMS_CLK_PERIOD_NS)
`endif

// [src/lpms_pkg.sv]
// types shared by the low power mode sequencer
package lpms_pkg;
    // power mode states, one-hot
    typedef enum logic [5:0] {
        ps_run = 6'h01,
        ps_sleep = 6'h02,
        ps_stop = 6'h04,
        ps_stop_regup = 6'h08,
        ps_stop_osc = 6'h10,
        ps_standby = 6'h20
    } lpms_state_e;
    typedef logic [7:0] lpms_addr_t;
    typedef logic [31:0] lpms_word_t;
endpackage

// [verif/lpms_far_side.sv]
// far side model: external oscillator and a serial port that borrows the rc clock
`timescale 1ns/1ps
module lpms_far_side (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bench controls
    input wire logic osc_run,
    input wire logic rx_start,
    // device side
    input wire logic periph_grant,
    output logic external_clock,
    output logic periph_req
);
    logic [1:0] div_reg; // divide by six keeps the sampler comfortable
    logic [2:0] use_reg; // granted cycles used so far
    // oscillator freezes when stopped, the way a dead crystal looks
    always_ff @(posedge clk) begin
        if (rst) begin
            div_reg <= 2'h0;
            external_clock <= 1'b0;
        end else if (osc_run) begin
            div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
            external_clock <= (div_reg == 2'h2) ? ~external_clock : external_clock;
        end
    end
    // request held until four granted cycles have passed
    always_ff @(posedge clk) begin
        if (rst || rx_start) begin
            periph_req <= rx_start;
            use_reg <= 3'h0;
        end else if (periph_req && periph_grant) begin
            use_reg <= use_reg + 3'h1;
            periph_req <= (use_reg != 3'h3);
        end
    end
endmodule

// [verif/tb_top.sv]
// register-level bench for the low power mode sequencer
`timescale 1ns/1ps
`include "lpms_cfg.svh"
module tb_top;
    import lpms_pkg::*;
    // bus and stimulus driven by the bench given values at time zero; device outputs are not
    logic clk = 1'b0, rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, core_sleep_req = 1'b0, core_wake_event = 1'b0;
    lpms_addr_t s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    lpms_word_t s_axi_wdata = 32'h0, s_axi_rdata, q;
    logic [3:0] s_axi_wstrb = 4'hf, periph_osc_grant, periph_osc_req;
    logic [15:0] external_event_lines = 16'h0;
    logic [8:0] internal_event_lines = 9'h0;
    logic [1:0] wakeup_pins = 2'h0, s_axi_bresp, s_axi_rresp, r;
    logic external_reset_pin_n = 1'b1, independent_watchdog_reset = 1'b0, rtc_event = 1'b0;
    logic osc_run = 1'b0, rx_start = 1'b0, preq, external_clock, irq, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, regulator_on, main_regulator_mode, regulator_hiz;
    logic core_power_on, core_domain_rst, cpu_clk_en, core_clk_en, pll_en, internal_rc_oscillator_en;
    logic external_crystal_oscillator_en, always_on_clk_en, sysclk_external;
    logic [5:0] obs; // watched levels for bounded waits
    int bad_count = 0, n_checks = 0, k;
    assign periph_osc_req = {3'h0, preq};
    assign obs = {irq, sysclk_external, periph_osc_grant[0], core_power_on, cpu_clk_en, core_clk_en};
    always #5 clk = ~clk;
    lpms_far_side far_u (.clk(clk), .rst(rst), .osc_run(osc_run), .rx_start(rx_start),
        .periph_grant(periph_osc_grant[0]), .external_clock(external_clock), .periph_req(preq));
    lpms_top dut_u (.*);
    task end_of_test;
        if (bad_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // waits at falling edges so the levels have settled; the bound ends a hang
    task wt(input int idx, input logic v, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(negedge clk);
            if (obs[idx] === v)
                break;
        end
        chk("wait_level", obs[idx], v);
        if (obs[idx] !== v)
            end_of_test();
    endtask
    // one write or one read; each channel dropped after the edge that takes it
    task bus(input logic wr, input lpms_addr_t a, input lpms_word_t d);
        logic pa, pw, pd;
        @(posedge clk);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        pd = 1'b0;
        for (int i = 0; i < 50 && !pd; i++) begin
            @(negedge clk);
            pa = (s_axi_awvalid & s_axi_awready) | (s_axi_arvalid & s_axi_arready);
            pw = s_axi_wvalid & s_axi_wready;
            pd = wr ? s_axi_bvalid : s_axi_rvalid;
            {q, r} = {s_axi_rdata, wr ? s_axi_bresp : s_axi_rresp};
            @(posedge clk);
            if (pa)
                {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
            if (pw)
                s_axi_wvalid <= 1'b0;
            if (pd)
                {s_axi_bready, s_axi_rready} <= 2'h0;
        end
        chk("bus_answer", pd, 1'b1);
        if (!pd)
            end_of_test();
    endtask
    task enter(input lpms_word_t c);
        bus(1'b1, `LPMS_OFF_CTRL, c);
        @(posedge clk) core_sleep_req <= 1'b1;
        @(posedge clk) core_sleep_req <= 1'b0;
    endtask
    // standby exit sources {reset pin n, watchdog, timer, pins}: pin, timer, watchdog, reset pin
    logic [4:0] stby_src [4] = '{5'h11, 5'h14, 5'h18, 5'h00};
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("reset_outs", {regulator_on, main_regulator_mode, sysclk_external,
            internal_rc_oscillator_en}, 32'hd);
        bus(1'b1, `LPMS_OFF_STAT, 32'h1);
        chk("stat_write_resp", r, `LPMS_RESP_SLVERR);
        bus(1'b0, 8'h20, 32'h0);
        chk("unmapped_read", q, 32'h0);
        enter(32'h0);
        wt(1, 1'b0, 20);
        chk("sleep_outs", {core_clk_en, main_regulator_mode}, 32'h3);
        @(posedge clk) core_wake_event <= 1'b1;
        wt(1, 1'b1, 20);
        @(posedge clk) core_wake_event <= 1'b0;
        bus(1'b1, `LPMS_OFF_OSCEN, 32'h1);
        enter(32'h5);
        wt(0, 1'b0, 20);
        chk("stop_outs", {pll_en, internal_rc_oscillator_en, external_crystal_oscillator_en,
            main_regulator_mode, regulator_on, always_on_clk_en}, 32'h3);
        bus(1'b0, `LPMS_OFF_STAT, 32'h0);
        chk("stop_status", q, 32'h4);
        @(posedge clk) rx_start <= 1'b1;
        @(posedge clk) rx_start <= 1'b0;
        wt(3, 1'b1, 300);
        chk("grant_outs", {main_regulator_mode, internal_rc_oscillator_en, core_clk_en}, 32'h6);
        wt(3, 1'b0, 50);
        @(posedge clk) external_event_lines <= 16'h8000;
        wt(1, 1'b1, 20);
        @(posedge clk) external_event_lines <= 16'h0;
        bus(1'b0, `LPMS_OFF_IRQ, 32'h0);
        chk("stop_wake_flag", q, 32'h1);
        bus(1'b1, `LPMS_OFF_IRQ, 32'h1);
        // stop with the regulator kept in main mode: the oscillator comes with no ramp
        enter(32'h1);
        wt(0, 1'b0, 20);
        chk("stop_main_reg", main_regulator_mode, 1'b1);
        @(posedge clk) rx_start <= 1'b1;
        @(posedge clk) rx_start <= 1'b0;
        wt(3, 1'b1, 20);
        chk("grant_main", internal_rc_oscillator_en, 1'b1);
        wt(3, 1'b0, 50);
        @(posedge clk) internal_event_lines <= 9'h001;
        wt(1, 1'b1, 20);
        @(posedge clk) internal_event_lines <= 9'h000;
        bus(1'b1, `LPMS_OFF_IRQ, 32'h1);
        for (k = 0; k < 4; k++) begin
            enter(32'h3);
            wt(2, 1'b0, 20);
            chk("standby_outs", {regulator_hiz, regulator_on, pll_en, internal_rc_oscillator_en,
                external_crystal_oscillator_en, always_on_clk_en,
                core_domain_rst}, 32'h43);
            @(posedge clk) {external_reset_pin_n, independent_watchdog_reset, rtc_event,
                wakeup_pins} <= stby_src[k];
            wt(1, 1'b1, 60);
            @(posedge clk) {external_reset_pin_n, independent_watchdog_reset, rtc_event,
                wakeup_pins} <= 5'h10;
            chk("standby_exit", {main_regulator_mode, sysclk_external, core_power_on}, 32'h5);
            bus(1'b0, `LPMS_OFF_IRQ, 32'h0);
            chk("standby_flag", q, 32'h2);
            bus(1'b1, `LPMS_OFF_IRQ, 32'h2);
        end
        bus(1'b1, `LPMS_OFF_MASK, 32'h4);
        bus(1'b1, `LPMS_OFF_CTRL, 32'h8);
        @(posedge clk) osc_run <= 1'b1;
        wt(4, 1'b1, 100);
        @(posedge clk) osc_run <= 1'b0;
        wt(4, 1'b0, 300);
        wt(5, 1'b1, 5);
        chk("fallback_rc", {internal_rc_oscillator_en, external_crystal_oscillator_en}, 32'h2);
        bus(1'b0, `LPMS_OFF_CTRL, 32'h0);
        chk("xtal_choice_dropped", q, 32'h0);
        bus(1'b1, `LPMS_OFF_MASK, 32'h0);
        chk("irq_masked", irq, 1'b0);
        bus(1'b1, `LPMS_OFF_IRQ, 32'h4);
        bus(1'b1, `LPMS_OFF_MASK, 32'h4);
        chk("irq_cleared", irq, 1'b0);
        end_of_test();
    end
endmodule
